// >>> test/brake_power_model.sv
/*
  power module stand-in: reads both brake switches back as feedback
  two clocks late; the high path can be held stuck for fault tests.
  assumes the sequencer's switch outputs and one shared clock.
*/
`default_nettype none
module brake_power_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // switch commands and fault injection
  input wire logic swHigh,
  input wire logic swLow,
  input wire logic stuckHigh,
  // feedback
  output logic fbHigh,
  output logic fbLow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pipeHigh;
  logic [1:0] pipeLow;
  // each path read back alone, so a single failure shows by itself
  // switches wired straight to the brake, no relay in between
  always @(posedge core_clk) begin
    if (rst) begin
      pipeHigh <= 2'h0;
      pipeLow <= 2'h0;
    end else begin
      pipeHigh <= {pipeHigh[0], swHigh};
      pipeLow <= {pipeLow[0], swLow};
    end
  end
  assign fbHigh = pipeHigh[1] | stuckHigh;
  assign fbLow = pipeLow[1];
endmodule : brake_power_model
`default_nettype wire

// >>> test/tb_timed_safe_stop_brake_ctrl.sv
/*
  self-checking bench for the safe stop and brake sequencer.
  assumes the power module model and the port monitor beside it.
*/
`default_nettype none
module tb_timed_safe_stop_brake_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0000_0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic stopReqCh1 = 1'b0;
  logic stopReqCh2 = 1'b0;
  logic torqueReqCh1 = 1'b0;
  logic torqueReqCh2 = 1'b0;
  logic monitorTrip = 1'b0;
  logic unitFault = 1'b0;
  logic stuckHigh = 1'b0;
  logic fbHigh, fbLow, quickStopRamp, pulseOff, brakeApply;
  logic brakeSwitchHigh, brakeSwitchLow, stopMsgCh1, stopMsgCh2;
  logic brakeModeWarn, rdPend;
  logic [31:0] expQ[$];
  logic [15:0] dly;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  always #5 core_clk = ~core_clk;
  timed_safe_stop_brake_ctrl dut (.core_clk, .rst, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .stopReqCh1, .stopReqCh2, .torqueReqCh1,
    .torqueReqCh2, .monitorTrip, .unitFault, .fbHigh, .fbLow,
    .quickStopRamp, .pulseOff, .brakeApply, .brakeSwitchHigh,
    .brakeSwitchLow, .stopMsgCh1, .stopMsgCh2, .brakeModeWarn);
  brake_power_model pm (.core_clk, .rst, .swHigh(brakeSwitchHigh),
    .swLow(brakeSwitchLow), .stuckHigh, .fbHigh, .fbLow);
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    // idle edge so a following call never re-raises the strobe at once
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    expQ.push_back(e);
    @(posedge core_clk);
    regRd <= 1'b0;
    @(posedge core_clk);
  endtask : rd
  // outputs packed: warn, msg2, msg1, ramp, pulse, apply, high, low
  task automatic look(input logic [7:0] e);
    @(negedge core_clk);
    chk({24'h0, brakeModeWarn, stopMsgCh2, stopMsgCh1, quickStopRamp,
      pulseOff, brakeApply, brakeSwitchHigh, brakeSwitchLow}, {24'h0, e});
    @(posedge core_clk);
  endtask : look
  ////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    rdPend <= regRd;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  // answer stands only in the cycle after the read strobe
  always @(negedge core_clk) begin
    if (rdPend === 1'b1 && expQ.size() > 0)
      chk(regRdata, expQ.pop_front());
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h1155));
    tick(2);
    look(8'h00);
    rst <= 1'b0;
    tick(1);
    rd(safe_stop_pkg::OFS_CTRL, 32'h0000_0000);
    wr(8'h20, $urandom());
    rd(8'h20, 32'h0000_0000);
    for (int m = 0; m < 4; m++) begin
      wr(safe_stop_pkg::OFS_CTRL, {26'h0, m[1:0], 4'hF});
      tick(3);
      rd(safe_stop_pkg::OFS_CTRL, {26'h0, m[1:0], 4'hF});
      look({(m == 0 || m == 3), 7'h03});
    end
    wr(safe_stop_pkg::OFS_CTRL, 32'h0000_001F);
    // direct torque off with a stuck high-side feedback
    stuckHigh <= 1'b1;
    torqueReqCh1 <= 1'b1;
    torqueReqCh2 <= 1'b1;
    tick(12);
    look(8'h0C);
    rd(safe_stop_pkg::OFS_FAULT, 32'h0000_0004);
    stuckHigh <= 1'b0;
    torqueReqCh1 <= 1'b0;
    torqueReqCh2 <= 1'b0;
    tick(4);
    chk({31'h0, brakeApply}, 32'h0000_0001);
    wr(safe_stop_pkg::OFS_FAULT, 32'h0000_0004);
    tick(12);
    rd(safe_stop_pkg::OFS_FAULT, 32'h0000_0000);
    look(8'h03);
    for (int i = 0; i < 2; i++) begin
      unitFault <= (i == 0);
      monitorTrip <= (i == 1);
      tick(4);
      chk({31'h0, brakeApply}, 32'h0000_0001);
      unitFault <= 1'b0;
      monitorTrip <= 1'b0;
      rd(safe_stop_pkg::OFS_FAULT, 32'h1 << i);
      wr(safe_stop_pkg::OFS_FAULT, 32'h0000_0003);
      tick(12);
    end
    // one delay only: stop must not select
    dly = 16'($urandom_range(16'hFFFF, 1));
    wr(safe_stop_pkg::OFS_DELAY1, {16'($urandom()), dly});
    rd(safe_stop_pkg::OFS_DELAY1, {16'h0, dly});
    stopReqCh1 <= 1'b1;
    stopReqCh2 <= 1'b1;
    tick(2);
    stopReqCh1 <= 1'b0;
    stopReqCh2 <= 1'b0;
    tick(4);
    look(8'h03);
    // equal nonzero delays in both channels, sized by the configurer
    wr(safe_stop_pkg::OFS_DELAY2, {16'h0, dly});
    wr(safe_stop_pkg::OFS_CTRL, 32'h0000_001C);
    stopReqCh1 <= 1'b1;
    stopReqCh2 <= 1'b1;
    tick(2);
    stopReqCh1 <= 1'b0;
    stopReqCh2 <= 1'b0;
    tick(4);
    look(8'h03);
    wr(safe_stop_pkg::OFS_CTRL, 32'h0000_001F);
    torqueReqCh1 <= 1'b1;
    torqueReqCh2 <= 1'b1;
    tick(4);
    look(8'h03);
    torqueReqCh1 <= 1'b0;
    torqueReqCh2 <= 1'b0;
    // one-cycle request, withdrawn at once
    stopReqCh1 <= 1'b1;
    stopReqCh2 <= 1'b1;
    tick(1);
    stopReqCh1 <= 1'b0;
    stopReqCh2 <= 1'b0;
    tick(6);
    look(8'h73);
    rd(safe_stop_pkg::OFS_STATEC, 32'h0000_0006);
    rd(safe_stop_pkg::OFS_MSG, 32'h0000_0003);
    tick(2);
    print_verdict();
  end
endmodule : tb_timed_safe_stop_brake_ctrl
`default_nettype wire

// >>> test/timed_safe_stop_brake_ctrl_monitor.sv
/*
  concurrent checks on the sequencer's ports.
  assumes one clock domain with synchronous active-high reset.
*/
`default_nettype none
module safe_stop_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // watched ports
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic stopReqCh1,
  input wire logic stopReqCh2,
  input wire logic monitorTrip,
  input wire logic unitFault,
  input wire logic quickStopRamp,
  input wire logic pulseOff,
  input wire logic brakeApply,
  input wire logic brakeSwitchHigh,
  input wire logic brakeSwitchLow,
  input wire logic stopMsgCh1
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  switch_follow_a: assert property (
    brakeApply |=> !brakeSwitchHigh && !brakeSwitchLow)
    else $error("brake switches stayed closed after apply");
  fault_apply_a: assert property (
    unitFault |-> ##[1:3] brakeApply)
    else $error("unit fault did not apply the brake");
  trip_apply_a: assert property (
    monitorTrip |-> ##[1:3] brakeApply)
    else $error("monitor trip did not apply the brake");
  ramp_msg_a: assert property (
    quickStopRamp |-> stopMsgCh1)
    else $error("ramp without running stop message");
  ramp_cause_a: assert property (
    $rose(quickStopRamp) |-> $past(stopReqCh1 && stopReqCh2, 2))
    else $error("ramp started without both channel requests");
  withdraw_hold_a: assert property (
    quickStopRamp && !stopReqCh1 |=>
      (quickStopRamp or ##[0:2] pulseOff))
    else $error("ramp ended early after withdrawal");
  release_cause_a: assert property (
    $rose(brakeSwitchHigh) |-> $past(!brakeApply))
    else $error("brake released while apply commanded");
  rdata_idle_a: assert property (
    !$past(regRd) |-> regRdata == 32'h0000_0000)
    else $error("read data outside read answer cycle");
endmodule : safe_stop_monitor
bind timed_safe_stop_brake_ctrl safe_stop_monitor u_mon (.core_clk,
  .rst, .regRd, .regRdata, .stopReqCh1, .stopReqCh2, .monitorTrip,
  .unitFault, .quickStopRamp, .pulseOff, .brakeApply, .brakeSwitchHigh,
  .brakeSwitchLow, .stopMsgCh1);
`default_nettype wire

// >>> verilog/brake_path_check.sv
/*
  two-path brake driver and diagnosis: drives high and low switches,
  compares feedback only after each commanded change.
  assumes feedback settles within a fixed count of clocks.
*/
`default_nettype none
module brake_path_check (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // command and feedback
  input wire logic applyCmd,
  input wire logic fbHigh,
  input wire logic fbLow,
  // outputs
  output logic swHigh,
  output logic swLow,
  output logic faultEvt
);
  typedef struct packed {
    logic hi;
    logic lo;
    logic prevApply;
    logic [safe_stop_pkg::FB_SETTLE_W-1:0] settle;
    logic chk;
    logic evt;
  } brk_s;
  brk_s st_r, st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.evt = 1'b0;
    // either path alone opening removes brake current
    st_nxt.hi = !applyCmd;
    st_nxt.lo = !applyCmd;
    st_nxt.prevApply = applyCmd;
    if (applyCmd != st_r.prevApply) begin
      st_nxt.settle = safe_stop_pkg::FB_SETTLE;
      st_nxt.chk = 1'b1;
    end else if (st_r.chk) begin
      if (st_r.settle != '0) begin
        st_nxt.settle = st_r.settle - 4'h1;
      end else begin
        st_nxt.chk = 1'b0;
        if (fbHigh != st_r.hi || fbLow != st_r.lo) begin
          st_nxt.evt = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.prevApply <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign swHigh = st_r.hi;
  assign swLow = st_r.lo;
  assign faultEvt = st_r.evt;
endmodule : brake_path_check
`default_nettype wire

// >>> verilog/safe_stop_pkg.sv
/*
  shared constants for the timed safe stop and safe brake sequencer:
  register offsets, fields, reset values, timing counts.
  assumes a 100 MHz core clock and a plain strobe register port.
*/
`default_nettype none
package safe_stop_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DELAY1 = 8'h04;
  localparam logic [7:0] OFS_DELAY2 = 8'h08;
  localparam logic [7:0] OFS_STATE1 = 8'h0C;
  localparam logic [7:0] OFS_STATE2 = 8'h10;
  localparam logic [7:0] OFS_STATEC = 8'h14;
  localparam logic [7:0] OFS_MSG = 8'h18;
  localparam logic [7:0] OFS_FAULT = 8'h1C;
  // control register fields
  localparam int CTL_TQ_EN1 = 0;
  localparam int CTL_TQ_EN2 = 1;
  localparam int CTL_BR_EN1 = 2;
  localparam int CTL_BR_EN2 = 3;
  localparam int CTL_MODE_LO = 4;
  localparam int CTL_MODE_W = 2;
  localparam int CTL_W = 6;
  localparam logic [CTL_W-1:0] CTL_RST = 6'h00;
  // status word fields
  localparam int ST_TQ_OFF = 0;
  localparam int ST_STOP_SEL = 1;
  localparam int ST_RAMP = 2;
  localparam int ST_BRAKE = 3;
  localparam int ST_FAULT = 4;
  localparam int ST_W = 5;
  // fault register fields
  localparam int FLT_CH1 = 0;
  localparam int FLT_CH2 = 1;
  localparam int FLT_BRAKE = 2;
  localparam int FLT_W = 3;
  // brake mode values for which safe brake control is discouraged
  localparam logic [CTL_MODE_W-1:0] MODE_NONE = 2'h0;
  localparam logic [CTL_MODE_W-1:0] MODE_ALT = 2'h3;
  // timing
  localparam int DELAY_W = 16;
  localparam int CLK_MHZ = 100;
  localparam int MON_CYCLE_US = 4000;
  localparam int IO_SAMPLE_US = 4000;
  localparam int MON_CYCLES = MON_CYCLE_US * CLK_MHZ;
  localparam int IO_CYCLES = IO_SAMPLE_US * CLK_MHZ;
  localparam int BRAKE_TYP_CYC = 4;
  localparam int BRAKE_MAX_CYC = 8;
  localparam int TICK_W = 32;
  localparam int FB_SETTLE_W = 4;
  localparam logic [FB_SETTLE_W-1:0] FB_SETTLE = 4'h8;
endpackage : safe_stop_pkg
`default_nettype wire

// >>> verilog/stop_delay_timer.sv
/*
  delay timer counting monitor ticks, loaded on start, runs to expiry
  regardless of withdrawal. assumes a one-cycle tick pulse.
*/
`default_nettype none
module stop_delay_timer (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic tick,
  input wire logic [safe_stop_pkg::DELAY_W-1:0] loadVal,
  // status
  output logic running,
  output logic expired
);
  typedef struct packed {
    logic [safe_stop_pkg::DELAY_W-1:0] cnt;
    logic run;
    logic exp;
  } tmr_s;
  tmr_s st_r, st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.exp = 1'b0;
    if (start && !st_r.run) begin
      st_nxt.cnt = loadVal;
      st_nxt.run = 1'b1;
    end else if (st_r.run && tick) begin
      if (st_r.cnt <= 16'h0001) begin
        st_nxt.run = 1'b0;
        st_nxt.exp = 1'b1;
        st_nxt.cnt = 16'h0000;
      end else begin
        st_nxt.cnt = st_r.cnt - 16'h0001;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign running = st_r.run;
  assign expired = st_r.exp;
endmodule : stop_delay_timer
`default_nettype wire

// >>> verilog/timed_safe_stop_brake_ctrl.sv
/*
  timed safe stop and safe brake control sequencer with register port.
  assumes synchronous inputs, single 100 MHz clock, strobe bus master.
*/
// Added by the designer: the register addresses and the address-and-strobe port.
// Functional notes
// - stop selected only if both delays nonzero
// - ramp down, then torque off at expiry
// - nonzero delay blocks direct terminal torque off (here only once both delays are nonzero)
// - timed stop needs torque off enabled
// - timer completes despite withdrawal, pulse torque off
// - both channels select, channel one ramps
// - state in status words or messages
// - brake commands sent over drive link
// - two independent brake switch paths
// - torque off or trip applies brake
// - brake control ignores ordinary brake mode
// - torque off applies brake, forces path test
// - brake needs both enables, safety enabled
// - power module cuts brake on unit fault
// - brake diagnosis only at state changes
// - any fault removes brake current, safe state
// - brake response four to eight cycles
// - quick one-channel retoggle: no message
`default_nettype none
module timed_safe_stop_brake_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // selection terminals, a stop and a torque request per channel, then the monitor trip and unit fault inputs
  input wire logic stopReqCh1,
  input wire logic stopReqCh2,
  input wire logic torqueReqCh1,
  input wire logic torqueReqCh2,
  input wire logic monitorTrip,
  input wire logic unitFault,
  // brake feedback from power module
  input wire logic fbHigh,
  input wire logic fbLow,
  // drive outputs
  output logic quickStopRamp,
  output logic pulseOff,
  output logic brakeApply,
  output logic brakeSwitchHigh,
  output logic brakeSwitchLow,
  output logic stopMsgCh1,
  output logic stopMsgCh2,
  output logic brakeModeWarn
);
  localparam logic [safe_stop_pkg::DELAY_W-1:0] DLY_ZERO = 16'h0000;

  function automatic logic [31:0] pad_st(
    input logic [safe_stop_pkg::ST_W-1:0] v);
    pad_st = {27'h000_0000, v};
  endfunction : pad_st

  ///////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [safe_stop_pkg::CTL_W-1:0] ctl;
    logic [safe_stop_pkg::DELAY_W-1:0] dly1;
    logic [safe_stop_pkg::DELAY_W-1:0] dly2;
    logic [safe_stop_pkg::TICK_W-1:0] tickCnt;
    logic tick;
    logic [3:0] brkCnt;
    logic brkPend;
    logic brkReq;
    logic [safe_stop_pkg::FLT_W-1:0] fault;
    logic ramp;
    logic pulse;
    logic brake;
    logic msg1;
    logic msg2;
    logic modeWarn;
    logic prevTq1;
    logic prevTq2;
    logic [31:0] rdata;
  } top_s;
  top_s st_r, st_nxt;

  logic stopSel;
  logic stopArmed;
  logic tmrRun;
  logic tmrExp;
  logic swHi;
  logic swLo;
  logic brkFaultEvt;
  logic brakeEn;
  logic tqEn;
  logic tqDirect;
  logic tqActive;
  logic safeReq;
  logic [safe_stop_pkg::ST_W-1:0] stateCh1;
  logic [safe_stop_pkg::ST_W-1:0] stateCh2;

  ///////////////////////////////////////////////////////////////////////
  // selection decode
  always_comb begin
    tqEn = st_r.ctl[safe_stop_pkg::CTL_TQ_EN1] &&
           st_r.ctl[safe_stop_pkg::CTL_TQ_EN2];
    stopArmed = (st_r.dly1 != DLY_ZERO) && (st_r.dly2 != DLY_ZERO)
                && tqEn;
    stopSel = stopArmed && stopReqCh1 && stopReqCh2;
    // direct terminal selection is locked out once both delays are set
    tqDirect = !stopArmed && tqEn &&
               (torqueReqCh1 || torqueReqCh2);
    tqActive = tqDirect || tmrExp;
    brakeEn = st_r.ctl[safe_stop_pkg::CTL_BR_EN1] &&
              st_r.ctl[safe_stop_pkg::CTL_BR_EN2] &&
              tqEn;
    safeReq = tqActive || monitorTrip || (st_r.fault != '0);
  end

  stop_delay_timer u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .start(stopSel),
    .tick(st_r.tick),
    .loadVal(st_r.dly1),
    .running(tmrRun),
    .expired(tmrExp)
  );

  brake_path_check u_brake (
    .core_clk(core_clk),
    .rst(rst),
    .applyCmd(st_r.brake),
    .fbHigh(fbHigh),
    .fbLow(fbLow),
    .swHigh(swHi),
    .swLow(swLo),
    .faultEvt(brkFaultEvt)
  );

  ///////////////////////////////////////////////////////////////////////
  // status words
  always_comb begin
    stateCh1 = '0;
    stateCh1[safe_stop_pkg::ST_TQ_OFF] = st_r.pulse;
    stateCh1[safe_stop_pkg::ST_STOP_SEL] = tmrRun;
    stateCh1[safe_stop_pkg::ST_RAMP] = st_r.ramp;
    stateCh1[safe_stop_pkg::ST_BRAKE] = st_r.brake;
    stateCh1[safe_stop_pkg::ST_FAULT] = st_r.fault[safe_stop_pkg::FLT_CH1];
    stateCh2 = stateCh1;
    stateCh2[safe_stop_pkg::ST_RAMP] = 1'b0;
    stateCh2[safe_stop_pkg::ST_FAULT] = st_r.fault[safe_stop_pkg::FLT_CH2];
  end

  ///////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    // monitor cycle tick
    st_nxt.tick = 1'b0;
    if (st_r.tickCnt >= 32'(safe_stop_pkg::MON_CYCLES - 1)) begin
      st_nxt.tickCnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.tickCnt = st_r.tickCnt + 32'h0000_0001;
    end
    // ramp held for the whole timer run, whatever channel one requests
    st_nxt.ramp = tmrRun && stopReqCh1;
    if (tmrRun) begin
      st_nxt.ramp = 1'b1;
    end
    st_nxt.pulse = safeReq;
    // brake command delayed by typical response in monitor ticks
    if (safeReq && brakeEn && !st_r.brake && !st_r.brkPend) begin
      st_nxt.brkPend = 1'b1;
      st_nxt.brkCnt = 4'(safe_stop_pkg::BRAKE_TYP_CYC);
    end else if (st_r.brkPend && st_r.tick) begin
      if (st_r.brkCnt <= 4'h1) begin
        st_nxt.brkPend = 1'b0;
        st_nxt.brkReq = 1'b1;
      end else begin
        st_nxt.brkCnt = st_r.brkCnt - 4'h1;
      end
    end
    if (!safeReq) begin
      st_nxt.brkReq = 1'b0;
      st_nxt.brkPend = 1'b0;
    end
    // any fault or unit failure drops brake current at once
    st_nxt.brake = (brakeEn && (st_r.brkReq || tqActive))
                   || (st_r.fault != '0) || unitFault;
    // mode only warns; it never changes brake action
    st_nxt.modeWarn = brakeEn &&
      (st_r.ctl[safe_stop_pkg::CTL_MODE_LO +: safe_stop_pkg::CTL_MODE_W]
        == safe_stop_pkg::MODE_NONE ||
       st_r.ctl[safe_stop_pkg::CTL_MODE_LO +: safe_stop_pkg::CTL_MODE_W]
        == safe_stop_pkg::MODE_ALT);
    st_nxt.msg1 = tmrRun;
    st_nxt.msg2 = tmrRun;
    // torque requests only stored; a one-channel retoggle cancels nothing, no fault raised
    st_nxt.prevTq1 = torqueReqCh1;
    st_nxt.prevTq2 = torqueReqCh2;
    // fault capture, set wins over software clear
    if (regWr && regAddr == safe_stop_pkg::OFS_FAULT) begin
      st_nxt.fault = st_r.fault & ~regWdata[safe_stop_pkg::FLT_W-1:0];
    end
    if (brkFaultEvt) begin
      st_nxt.fault[safe_stop_pkg::FLT_BRAKE] = 1'b1;
    end
    if (unitFault) begin
      st_nxt.fault[safe_stop_pkg::FLT_CH1] = 1'b1;
    end
    if (monitorTrip) begin
      st_nxt.fault[safe_stop_pkg::FLT_CH2] = 1'b1;
    end
    // register writes
    if (regWr) begin
      case (regAddr)
        safe_stop_pkg::OFS_CTRL:
          st_nxt.ctl = regWdata[safe_stop_pkg::CTL_W-1:0];
        safe_stop_pkg::OFS_DELAY1:
          st_nxt.dly1 = regWdata[safe_stop_pkg::DELAY_W-1:0];
        safe_stop_pkg::OFS_DELAY2:
          st_nxt.dly2 = regWdata[safe_stop_pkg::DELAY_W-1:0];
        default: ;
      endcase
    end
    // register reads, answer next cycle
    st_nxt.rdata = '0;
    if (regRd) begin
      case (regAddr)
        safe_stop_pkg::OFS_CTRL:
          st_nxt.rdata = {26'h000_0000, st_r.ctl};
        safe_stop_pkg::OFS_DELAY1: st_nxt.rdata = {16'h0000, st_r.dly1};
        safe_stop_pkg::OFS_DELAY2: st_nxt.rdata = {16'h0000, st_r.dly2};
        safe_stop_pkg::OFS_STATE1: st_nxt.rdata = pad_st(stateCh1);
        safe_stop_pkg::OFS_STATE2: st_nxt.rdata = pad_st(stateCh2);
        safe_stop_pkg::OFS_STATEC:
          st_nxt.rdata = pad_st(stateCh1 | stateCh2);
        safe_stop_pkg::OFS_MSG:
          st_nxt.rdata = {30'h0000_0000, st_r.msg2, st_r.msg1};
        safe_stop_pkg::OFS_FAULT:
          st_nxt.rdata = {29'h0000_0000, st_r.fault};
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.ctl <= safe_stop_pkg::CTL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ///////////////////////////////////////////////////////////////////////
  // outputs from flip-flops; brake link commands
  assign regRdata = st_r.rdata;
  assign quickStopRamp = st_r.ramp;
  assign pulseOff = st_r.pulse;
  assign brakeApply = st_r.brake;
  assign brakeSwitchHigh = swHi;
  assign brakeSwitchLow = swLo;
  assign stopMsgCh1 = st_r.msg1;
  assign stopMsgCh2 = st_r.msg2;
  assign brakeModeWarn = st_r.modeWarn;
endmodule : timed_safe_stop_brake_ctrl
`default_nettype wire
